// *** spfp_cfg.svh ***
// Purpose: constants of the supply-pulse fuse programmer
// Assumes: 200 MHz core clock
// Notes: times in us, counts derived from them
`ifndef SPFP_CFG_SVH
`define SPFP_CFG_SVH
`define SPFP_CLK_MHZ 200
`define SPFP_T_QUAL_US 10
`define SPFP_T_BLOW_US 90
`define SPFP_QUAL_CYC (`SPFP_T_QUAL_US * `SPFP_CLK_MHZ)
`define SPFP_BLOW_CYC (`SPFP_T_BLOW_US * `SPFP_CLK_MHZ)
`define SPFP_AW 8
`define SPFP_K_PAR 5'h01
`define SPFP_K_HYS 5'h03
`define SPFP_K_DOWN 5'h04
`define SPFP_K_FLO 5'h07
`define SPFP_K_FHI 5'h08
`define SPFP_K_BITW 5'h09
`define SPFP_K_MODE 5'h0B
`define SPFP_OP_MAX 6'h3F
`define SPFP_HYS_MAX 2'h3
`define SPFP_CODE_INIT 6'h01
`define SPFP_ADDR_INIT 8'h01
`define SPFP_LOCK_BIT 4
`define SPFP_OFS_CTRL 8'h00
`define SPFP_OFS_STAT 8'h04
`define SPFP_OFS_CODE 8'h08
`define SPFP_CTRL_RST 1'b0
`define SPFP_RESP_OK 2'h0
`define SPFP_RESP_ERR 2'h2
`endif

// *** spfp_pkg.sv ***
// Purpose: types of the supply-pulse fuse programmer
// Assumes: nothing
// Notes: fuse struct order matches the sense bus
package spfp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_H1 = 3'h1, ST_H1M = 3'h2,
    ST_TRY = 3'h3, ST_ADDR = 3'h4, ST_SPENT = 3'h5
  } spfp_state_t;
  typedef enum logic [1:0] {B_BOP = 2'h0, SWITCH_HYSTERESIS = 2'h1, B_PAR = 2'h2} spfp_base_t;
  typedef enum logic [2:0] {
    TM_UP = 3'h0, TM_DOWN = 3'h1, TM_BIT = 3'h2, TM_HYS = 3'h3, TM_PAR = 3'h4
  } spfp_tm_t;
  typedef struct packed {
    logic par;
    logic lock;
    logic [1:0] hys;
    logic [5:0] bop;
  } spfp_fuse_t;
  typedef struct packed {
    logic lock;
    logic burn;
    logic iup;
    logic chk_hi;
    logic chk_lo;
    logic [4:0] m;
    spfp_tm_t tm;
    spfp_state_t st;
  } spfp_stat_t;
  typedef struct packed {
    spfp_fuse_t fuses;
    logic [5:0] op;
    logic [1:0] hy;
  } spfp_code_t;
  typedef struct packed {
    logic [1:0] sm, sh, mf;
    spfp_fuse_t fs1, fs2;
    logic pa;
    logic [15:0] pc, hc;
    spfp_state_t st;
    spfp_base_t base;
    spfp_tm_t tm;
    logic [4:0] m;
    logic [5:0] op;
    logic [1:0] hy;
    logic par;
    logic [7:0] addr;
    logic burn;
    spfp_fuse_t bsel;
    logic [5:0] op_o;
    logic [1:0] hy_o;
    logic chk_lo, chk_hi, iup, off;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awa;
    logic [31:0] wd, rdata;
    logic [3:0] ws;
    logic [1:0] bresp, rresp;
  } spfp_regs_t;
endpackage : spfp_pkg

// *** spfp_prog.sv ***
// Purpose: supply-pulse key decoder, try counters, fuse blow control
// Assumes: supply level comparators and fuse sense are asynchronous
// Notes: fuses themselves sit outside; this logic steers them
`timescale 1ns/1ps
`include "spfp_cfg.svh"
`default_nettype none
module spfp_prog
  import spfp_pkg::*;
#(
  parameter logic [15:0] BLOW_CYC = 16'(`SPFP_BLOW_CYC),
  parameter logic [15:0] QUAL_CYC = 16'(`SPFP_QUAL_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply level comparators
  input wire logic prog_level_mid,
  input wire logic prog_level_high,
  // Fuse array
  input wire spfp_fuse_t fuse_sense,
  input wire logic fuse_margin_fail,
  output logic fuse_burn_en,
  output spfp_fuse_t fuse_burn_sel,
  output logic check_blown_en,
  output logic check_intact_en,
  output logic supply_current,
  // Analog trims
  output logic [5:0] operate_point,
  output logic [1:0] switch_hysteresis,
  // AXI4-Lite slave
  input wire logic [`SPFP_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SPFP_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [1:0] rsync;
  logic rst_s;
  spfp_regs_t q, d;
  logic act, evq, evh, evm, lock;

  // Every check runs on the core clock and sleeps during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s);

  // ********************************
  // Reset release
  // ********************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_s = rsync[1];

  // ********************************
  // Pulse events
  // ********************************
  assign act = q.sm[1] | q.sh[1];
  assign evq = q.pa & !act & (q.pc >= QUAL_CYC);
  assign evh = evq & (q.hc >= QUAL_CYC);
  assign evm = evq & !evh;
  assign lock = q.fs2.lock;

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    spfp_fuse_t sel;
    spfp_stat_t stat;
    spfp_code_t code;
    logic clr, try_on, win;
    sel = '0;
    stat = '0;
    code = '0;
    clr = 1'b0;
    try_on = 1'b0;
    win = 1'b0;
    d = q;
    d.sm = {q.sm[0], prog_level_mid};
    d.sh = {q.sh[0], prog_level_high};
    d.mf = {q.mf[0], fuse_margin_fail};
    d.fs1 = fuse_sense;
    d.fs2 = q.fs1;
    d.pa = act;
    // Saturate so a stuck supply cannot roll the count over
    d.pc = !act ? 16'h0 : (&q.pc ? q.pc : q.pc + 16'h1);
    d.hc = !q.sh[1] ? 16'h0 : (&q.hc ? q.hc : q.hc + 16'h1);

    // Register write, both channels in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `SPFP_RESP_OK;
      unique case (q.awa)
        `SPFP_OFS_CTRL: begin
          if (q.ws[0]) begin
            d.off = q.wd[0];
            clr = q.wd[1];
          end
        end
        `SPFP_OFS_STAT, `SPFP_OFS_CODE: ;
        default: d.bresp = `SPFP_RESP_ERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;

    // Register read
    stat.lock = lock;
    stat.burn = q.burn;
    stat.iup = q.iup;
    stat.chk_hi = q.chk_hi;
    stat.chk_lo = q.chk_lo;
    stat.m = q.m;
    stat.tm = q.tm;
    stat.st = q.st;
    code.fuses = q.fs2;
    code.op = q.op_o;
    code.hy = q.hy_o;
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `SPFP_RESP_OK;
      unique case (s_axi_araddr)
        `SPFP_OFS_CTRL: d.rdata = {31'h0, q.off};
        `SPFP_OFS_STAT: d.rdata = 32'(stat);
        `SPFP_OFS_CODE: d.rdata = 32'(code);
        default: begin
          d.rdata = 32'h0;
          d.rresp = `SPFP_RESP_ERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.arready = !d.rvalid;

    // ********************************
    // Key decoder, acts on pulse falling edges
    // ********************************
    if (q.off || clr) begin
      d.st = ST_IDLE;
    end else if (evq) begin
      unique case (q.st)
        ST_IDLE: begin
          if (evh) d.st = ST_H1;
        end
        ST_H1: begin
          if (evh) begin
            d.st = ST_TRY;
            d.base = B_BOP;
            d.tm = TM_UP;
            d.op = `SPFP_CODE_INIT;
            d.m = 5'h0;
          end else begin
            d.st = ST_H1M;
            d.m = 5'h1;
          end
        end
        ST_H1M: begin
          if (evm) begin
            d.m = q.m + 5'h1;
            if (q.m == `SPFP_K_HYS) d.st = ST_IDLE;
          end else if (q.m == `SPFP_K_PAR) begin
            d.st = ST_TRY;
            d.base = B_PAR;
            d.tm = TM_PAR;
            d.par = 1'b1;
            d.m = 5'h0;
          end else if (q.m == `SPFP_K_HYS) begin
            d.st = ST_TRY;
            d.base = SWITCH_HYSTERESIS;
            d.tm = TM_HYS;
            d.hy = 2'h1;
            d.m = 5'h0;
          end else begin
            d.st = ST_IDLE;
          end
        end
        ST_TRY: begin
          if (evm) begin
            d.m = &q.m ? q.m : q.m + 5'h1;
            unique case (q.tm)
              TM_UP: d.op = (q.op == `SPFP_OP_MAX) ? 6'h0 : q.op + 6'h1;
              TM_DOWN: d.op = (q.op == 6'h0) ? `SPFP_OP_MAX : q.op - 6'h1;
              TM_BIT: d.op = (q.op == 6'h0) ? 6'h1 : {q.op[4:0], 1'b0};
              TM_HYS: if (q.hy != `SPFP_HYS_MAX) d.hy = q.hy + 2'h1;
              TM_PAR: d.par = 1'b1;
              default: d.st = ST_IDLE;
            endcase
          end else if (q.m == `SPFP_K_MODE && q.tm inside {TM_UP, TM_HYS, TM_PAR}) begin
            d.st = ST_ADDR;
            d.addr = `SPFP_ADDR_INIT;
          end else if (q.tm == TM_UP && q.m == `SPFP_K_DOWN) begin
            d.tm = TM_DOWN;
            d.op = `SPFP_OP_MAX;
          end else if (q.tm == TM_UP && q.m == `SPFP_K_BITW) begin
            d.tm = TM_BIT;
            d.op = 6'h1;
          end else begin
            d.st = ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (evm) d.addr = {q.addr[6:0], 1'b0};
          else d.st = ST_SPENT;
        end
        ST_SPENT: ;
        default: d.st = ST_IDLE;
      endcase
    end

    // ********************************
    // Fuse burn window
    // ********************************
    // Base register and one-hot address pick at most one fuse
    unique case (q.base)
      B_BOP: sel.bop = q.addr[5:0];
      SWITCH_HYSTERESIS: begin
        sel.hys = q.addr[1:0];
        sel.lock = q.addr[`SPFP_LOCK_BIT];
      end
      B_PAR: sel.par = q.addr[0] & ^q.fs2[7:0];
      default: sel = '0;
    endcase
    if (lock) sel = '0;
    // Window closes after the blow time so a stuck supply cannot overheat the fuse
    win = (q.st == ST_ADDR) && q.sh[1] && !q.off &&
      (q.hc >= QUAL_CYC) && (q.hc < BLOW_CYC);
    d.burn = win && (|sel);
    d.bsel = win ? sel : spfp_fuse_t'('0);

    // ********************************
    // Trim outputs and fuse check
    // ********************************
    try_on = (q.st == ST_TRY) && !lock;
    d.op_o = (try_on && q.base == B_BOP) ? q.op : q.fs2.bop;
    d.hy_o = (try_on && q.base == SWITCH_HYSTERESIS) ? q.hy : q.fs2.hys;
    d.chk_lo = (q.st == ST_TRY) && q.base == SWITCH_HYSTERESIS && q.m == `SPFP_K_FLO;
    d.chk_hi = (q.st == ST_TRY) && q.base == SWITCH_HYSTERESIS && q.m == `SPFP_K_FHI;
    d.iup = (q.chk_lo || q.chk_hi) && q.mf[1];
  end

  // ********************************
  // State register
  // ********************************
  // All try state is volatile and cleared by power-on reset
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fuse_burn_en = q.burn;
  assign fuse_burn_sel = q.bsel;
  assign check_blown_en = q.chk_hi;
  assign check_intact_en = q.chk_lo;
  assign supply_current = q.iup;
  assign operate_point = q.op_o;
  assign switch_hysteresis = q.hy_o;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

  // ********************************
  // Checks
  // ********************************

  AST_TRY_PRESET: assert property (
    (q.st == ST_H1 && evh && !q.off) |=> (q.st == ST_TRY && q.op == 6'h01 && q.tm == TM_UP))
    else $error("try entry did not preset code 1");
  AST_UP_STEP: assert property (
    (q.st == ST_TRY && q.tm == TM_UP && evm && !q.off && q.op != 6'h3F)
    |=> q.op == $past(q.op) + 6'h1)
    else $error("up count did not step by one");
  AST_UP_WRAP: assert property (
    (q.st == ST_TRY && q.tm == TM_UP && evm && !q.off && q.op == 6'h3F) |=> q.op == 6'h0)
    else $error("up count did not wrap to 0");
  AST_DOWN_ENTRY: assert property (
    (q.st == ST_TRY && q.tm == TM_UP && evh && !q.off && q.m == 5'h04)
    |=> (q.tm == TM_DOWN && q.op == 6'h3F))
    else $error("down register not entered at 63");
  AST_MODE_KEY: assert property (
    (q.st == ST_TRY && q.tm == TM_HYS && evh && !q.off && q.m == 5'h0B)
    |=> (q.st == ST_ADDR && q.addr == 8'h01))
    else $error("blow mode key not honoured");
  AST_ADDR_SHIFT: assert property (
    (q.st == ST_ADDR && evm && !q.off) |=> (q.addr == {$past(q.addr[6:0]), 1'b0}))
    else $error("blow address did not shift");
  AST_ONE_FUSE: assert property (
    fuse_burn_en |-> $onehot(fuse_burn_sel))
    else $error("more than one fuse selected");
  AST_LOCK_REFUSE: assert property (
    (lock && $past(lock)) |-> ##1 (!fuse_burn_en && operate_point == $past(q.fs2.bop)))
    else $error("access after lock");
  AST_MARGIN_CURRENT: assert property (
    (check_blown_en && q.mf[1]) |=> supply_current)
    else $error("marginal fuse did not raise current");
  AST_NOISE_IDLE: assert property (
    (q.st == ST_H1M && evh && !q.off && q.m != 5'h01 && q.m != 5'h03) |=> q.st == ST_IDLE)
    else $error("unknown key not rejected");

  COV_TRY_UP: cover property (q.st == ST_TRY && q.tm == TM_UP && evm);
  COV_BURN: cover property (fuse_burn_en ##1 !fuse_burn_en);
  COV_CHECK: cover property (check_intact_en && supply_current);
  COV_AXI_WR: cover property (s_axi_bvalid && s_axi_bready);

endmodule : spfp_prog
`default_nettype wire

// *** spfp_supply_model.sv ***
// Purpose: programmable supply pulsing the supply pin, plus the fuse array
// Assumes: the comparators report mid whenever the high level is applied
// Notes: pulse widths are parameters, shortened so the run stays short
`timescale 1ns/1ps
`default_nettype none
module spfp_supply_model
  import spfp_pkg::*;
#(
  parameter int T_ACT = 2030,
  parameter int T_LOW = 60
) (
  // Clock
  input wire logic clk,
  // Supply comparators
  output logic lvl_mid,
  output logic lvl_high,
  // Fuse array
  input wire logic burn_en,
  input wire spfp_fuse_t burn_sel,
  output spfp_fuse_t fuse_sense
);
  spfp_fuse_t blown = '0;

  initial begin
    lvl_mid = 1'b0;
    lvl_high = 1'b0;
  end

  // No reset: a fuse once burnt survives every power cycle
  always @(posedge clk) begin
    if (burn_en) begin
      blown <= blown | burn_sel;
    end
  end
  assign fuse_sense = blown;

  // One pulse; a high level also lifts the mid comparator
  task automatic pulse(input logic hi, input int len);
    @(posedge clk);
    lvl_mid <= 1'b1;
    lvl_high <= hi;
    repeat (len) @(posedge clk);
    lvl_mid <= 1'b0;
    lvl_high <= 1'b0;
    repeat (T_LOW) @(posedge clk);
  endtask : pulse

  task automatic key(input logic hi, input int n);
    repeat (n) pulse(hi, T_ACT);
  endtask : key
endmodule : spfp_supply_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the supply-pulse fuse programmer
// Assumes: the supply model drives the comparators and holds the fuses
// Notes: qualify and blow windows shortened through parameters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spfp_pkg::*;
  localparam int QUAL = 200;
  localparam int BLOW = 500;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic margin = 1'b0;
  logic lvl_mid, lvl_high, burn_en, chk_blown, chk_intact, sup_cur;
  spfp_fuse_t fsense, burn_sel;
  logic [5:0] op;
  logic [1:0] hys;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata, d;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int err_total = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  spfp_prog #(.BLOW_CYC(16'(BLOW)), .QUAL_CYC(16'(QUAL))) uut (
    .clk(clk), .rst_n(rst_n), .prog_level_mid(lvl_mid), .prog_level_high(lvl_high),
    .fuse_sense(fsense), .fuse_margin_fail(margin), .fuse_burn_en(burn_en),
    .fuse_burn_sel(burn_sel), .check_blown_en(chk_blown), .check_intact_en(chk_intact),
    .supply_current(sup_cur), .operate_point(op), .switch_hysteresis(hys),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  spfp_supply_model #(.T_ACT(QUAL + 30)) u_sup (
    .clk(clk), .lvl_mid(lvl_mid), .lvl_high(lvl_high),
    .burn_en(burn_en), .burn_sel(burn_sel), .fuse_sense(fsense));

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    rs = bresp;
    bready <= 1'b0;
    // Let an edge pass so a next call never re-raises in this step
    @(posedge clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : bus_rd

  // Power cycle: only burnt fuses survive
  task automatic power_cycle();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : power_cycle

  // ****************
  // Scenarios
  // ****************
  task automatic t_bus();
    bus_wr(8'h00, 32'h0, r);
    chk("ctrl_wresp", 32'(r), 32'h0);
    bus_rd(8'h00, d, r);
    chk("ctrl_rd", d, 32'h0);
    bus_rd(8'h0C, d, r);
    chk("unmapped_resp", 32'(r), 32'h2);
    chk("unmapped_data", d, 32'h0);
    bus_wr(8'h0C, 32'h1, r);
    chk("unmapped_wresp", 32'(r), 32'h2);
    bus_wr(8'h00, 32'h1, r);
    u_sup.key(1'b1, 2);
    bus_rd(8'h04, d, r);
    chk("off_state", 32'(d[2:0]), 32'h0);
    chk("off_code", 32'(op), 32'h0);
    bus_rd(8'h00, d, r);
    chk("ctrl_off_rd", d, 32'h1);
    bus_wr(8'h00, 32'h0, r);
  endtask : t_bus

  task automatic t_up();
    u_sup.key(1'b1, 2);
    chk("up_entry", 32'(op), 32'h1);
    bus_rd(8'h04, d, r);
    chk("up_state", 32'(d[2:0]), 32'h3);
    u_sup.pulse(1'b0, QUAL - 50);
    chk("short_pulse", 32'(op), 32'h1);
    u_sup.key(1'b0, 1);
    chk("up_step", 32'(op), 32'h2);
  endtask : t_up

  task automatic t_down();
    power_cycle();
    u_sup.key(1'b1, 2);
    u_sup.key(1'b0, 4);
    u_sup.key(1'b1, 1);
    chk("down_entry", 32'(op), 32'h3F);
    u_sup.key(1'b0, 1);
    chk("down_step", 32'(op), 32'h3E);
  endtask : t_down

  task automatic t_hys();
    power_cycle();
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 2);
    u_sup.key(1'b1, 1);
    bus_rd(8'h04, d, r);
    chk("stray_key", 32'(d[2:0]), 32'h0);
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 3);
    u_sup.key(1'b1, 1);
    chk("hys_entry", 32'(hys), 32'h1);
    u_sup.key(1'b0, 6);
    margin <= 1'b1;
    repeat (10) @(posedge clk);
    chk("no_check_current", 32'(sup_cur), 32'h0);
    u_sup.key(1'b0, 1);
    chk("intact_check", 32'(chk_intact), 32'h1);
    chk("check_current", 32'(sup_cur), 32'h1);
    chk("hys_sat", 32'(hys), 32'h3);
    u_sup.key(1'b0, 1);
    chk("blown_check", 32'({chk_blown, chk_intact}), 32'h2);
    margin <= 1'b0;
    bus_wr(8'h00, 32'h2, r);
    bus_rd(8'h04, d, r);
    chk("clear_state", 32'(d[2:0]), 32'h0);
  endtask : t_hys

  task automatic t_blow();
    power_cycle();
    u_sup.key(1'b1, 2);
    u_sup.key(1'b0, 11);
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 3);
    u_sup.pulse(1'b1, BLOW + 200);
    chk("burnt_fuse", 32'(fsense), 32'h008);
    power_cycle();
    chk("stored_code", 32'(op), 32'h8);
  endtask : t_blow

  task automatic t_par();
    power_cycle();
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 1);
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 11);
    u_sup.key(1'b1, 1);
    u_sup.pulse(1'b1, BLOW + 200);
    chk("parity_fuse", 32'(fsense), 32'h208);
  endtask : t_par

  task automatic t_lock();
    power_cycle();
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 3);
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 11);
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 4);
    u_sup.pulse(1'b1, BLOW + 200);
    chk("lock_fuse", 32'(fsense), 32'h308);
    power_cycle();
    bus_rd(8'h04, d, r);
    chk("lock_state", 32'(d[15]), 32'h1);
    u_sup.key(1'b1, 2);
    chk("locked_op", 32'(op), 32'h8);
    power_cycle();
    u_sup.key(1'b1, 1);
    u_sup.key(1'b0, 3);
    u_sup.key(1'b1, 1);
    chk("locked_hys", 32'(hys), 32'h0);
    u_sup.key(1'b0, 7);
    chk("locked_check", 32'(chk_intact), 32'h1);
  endtask : t_lock

  // ****************
  // Run control
  // ****************
  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Sized for about 31k cycles of pulses
  initial begin
    repeat (45000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    power_cycle();
    t_bus();
    t_up();
    t_down();
    t_hys();
    t_blow();
    t_par();
    t_lock();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
